// >>> hw/sahc_consts.svh
// Constants for the APPROXIMATION_REGISTER converter control block
// What this block does
// - Start conversion on convert_start_n falling edge only with chip select low.
// - Drive data outputs only while read and chip select are both low.
// - Busy output low during conversion, high otherwise.
// - Result valid in output latches when busy rises.
// - Sleep low forces lowest power and reference_ready low.
// - Reference_ready rises only after reference settles following sleep release.
// - Reference wake-up delay is about 4.2 ms.
// - Nap low shuts down all but reference; host waits 620 ns after release.
// - High byte select: bits 11..8 on low four lines, upper four low.
// - Byte variant: straight binary unipolar, offset binary bipolar.
// - Full-width variant: bipolar results in two's complement.
// - Full-width variant: twelve bits in parallel, bit 11 most significant.
// - Strap for negative supply selects unipolar or bipolar.
// - Approximation register cleared at start of every conversion.
// - Start edges ignored during conversion; no abort or restart.
// - Bits decided one per step, most significant first.
// - Completed register copied into output latches at conversion end.
// - Conversion steps timed by internal clock only.
// - Conversion takes about 6 us.
`ifndef SAHC_CONSTS_SVH
`define SAHC_CONSTS_SVH
`define SAHC_CLK_PERIOD_NS   10
`define SAHC_CONV_TIME_NS    6000
`define SAHC_WAKE_TIME_US    4200
`define SAHC_NAP_WAKE_NS     620
`define SAHC_RES_BITS        12
`define SAHC_MSB_IDX         11
`define SAHC_BYTE_BITS       8
`define SAHC_NIBBLE_BITS     4
`define SAHC_CONV_CYCLES     (`SAHC_CONV_TIME_NS / `SAHC_CLK_PERIOD_NS)
`define SAHC_WAKE_CYCLES     (`SAHC_WAKE_TIME_US * 1000 / `SAHC_CLK_PERIOD_NS)
`define SAHC_NAP_CYCLES      ((`SAHC_NAP_WAKE_NS + `SAHC_CLK_PERIOD_NS - 1) / `SAHC_CLK_PERIOD_NS)
`endif

// >>> hw/sahc_pkg.sv
// Types for the APPROXIMATION_REGISTER converter control block
`default_nettype none
package sahc_pkg;
    typedef enum logic [1:0] {SAHC_IDLE, SAHC_SETTLE, SAHC_DECIDE, SAHC_FINISH} sahc_state_t;
endpackage : sahc_pkg
`default_nettype wire

// >>> hw/sahc_top.sv
// Conversion control, result latch and three-state readout
`include "sahc_consts.svh"
`default_nettype none
module sahc_top #(
    parameter int RES_BITS     = `SAHC_RES_BITS,
    parameter int CONV_CYCLES  = `SAHC_CONV_CYCLES,
    parameter int WAKE_CYCLES  = `SAHC_WAKE_CYCLES,
    parameter int NAP_CYCLES   = `SAHC_NAP_CYCLES,
    parameter bit BYTE_VARIANT = 1'b0
) (
    input  wire logic                clock_i,
    input  wire logic                rst_n_i,
    input  wire logic                chip_select_n_i,
    input  wire logic                read_n_i,
    input  wire logic                convert_start_n_i,
    input  wire logic                upper_byte_select_i,
    input  wire logic                sleep_n_i,
    input  wire logic                nap_n_i,
    input  wire logic                bipolar_strap_i,
    input  wire logic                comparator_i,
    output logic [RES_BITS-1:0]      data_o,
    output logic [RES_BITS-1:0]      data_oe_o,
    output logic                     busy_n_o,
    output logic                     reference_ready_o,
    output logic [RES_BITS-1:0]      trial_word_o,
    output logic                     sample_hold_o,
    output logic                     powered_down_o,
    output logic                     core_awake_o
);
    // One settle slot plus one slot per result bit fills the conversion time
    localparam int STEP_CYCLES = CONV_CYCLES / (RES_BITS + 1);
    localparam int CNT_W       = $clog2(WAKE_CYCLES + 1);
    localparam int STEP_W      = $clog2(STEP_CYCLES + 1);
    localparam int NAP_W       = $clog2(NAP_CYCLES + 1);

    // Datapath slices assume twelve bits; each counter needs a nonzero load
    if (RES_BITS != `SAHC_RES_BITS || STEP_CYCLES < 1 || NAP_CYCLES < 1
        || WAKE_CYCLES < 1) begin : g_bad_params
        $error("sahc_top: unsupported parameters");
    end

    // Input synchronisers, two flops each
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic [6:0] raw_in;
    assign raw_in = {comparator_i, bipolar_strap_i, nap_n_i, sleep_n_i,
                     upper_byte_select_i, convert_start_n_i, read_n_i ^ 1'b0};
    logic cs_in;
    assign cs_in = chip_select_n_i;
    logic cs1_r;
    logic cs2_r;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= 7'h1F;
            sync2_r <= 7'h1F;
            cs1_r   <= 1'b1;
            cs2_r   <= 1'b1;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            cs1_r   <= cs_in;
            cs2_r   <= cs1_r;
        end
    end

    logic rd_s;
    logic cv_s;
    logic hb_s;
    logic sl_s;
    logic np_s;
    logic bp_s;
    logic cmp_s;
    assign rd_s  = sync2_r[0];
    assign cv_s  = sync2_r[1];
    assign hb_s  = sync2_r[2];
    assign sl_s  = sync2_r[3];
    assign np_s  = sync2_r[4];
    assign bp_s  = sync2_r[5];
    assign cmp_s = sync2_r[6];

    // Conversion state
    sahc_pkg::sahc_state_t state_r, state_nxt;
    logic                cv_d_r, cv_d_nxt;
    logic [RES_BITS-1:0] sar_r, sar_nxt;
    logic [RES_BITS-1:0] latch_r, latch_nxt;
    logic [3:0]          bit_r, bit_nxt;
    logic [STEP_W-1:0]   step_r, step_nxt;
    logic                busy_n_r, busy_n_nxt;
    logic                bip_r, bip_nxt;
    logic                start_evt;

    // Chip-select and power-mode gating of the start edge
    assign start_evt = cv_d_r && !cv_s && !cs2_r && sl_s && core_awake_o;

    always_comb begin
        state_nxt  = state_r;
        cv_d_nxt   = cv_s;
        sar_nxt    = sar_r;
        latch_nxt  = latch_r;
        bit_nxt    = bit_r;
        step_nxt   = step_r;
        busy_n_nxt = busy_n_r;
        bip_nxt    = bip_r;
        unique case (state_r)
            sahc_pkg::SAHC_IDLE: begin
                busy_n_nxt = 1'b1;
                bip_nxt    = bp_s;
                if (start_evt) begin
                    sar_nxt    = '0;
                    sar_nxt[`SAHC_MSB_IDX] = 1'b1;
                    bit_nxt    = 4'(`SAHC_MSB_IDX);
                    step_nxt   = STEP_W'(STEP_CYCLES - 1);
                    busy_n_nxt = 1'b0;
                    state_nxt  = sahc_pkg::SAHC_SETTLE;
                end
            end
            sahc_pkg::SAHC_SETTLE: begin
                // Acquisition hold-off before first decision; start edges ignored
                if (step_r == '0) begin
                    step_nxt  = STEP_W'(STEP_CYCLES - 1);
                    state_nxt = sahc_pkg::SAHC_DECIDE;
                end else begin
                    step_nxt = step_r - STEP_W'(1);
                end
            end
            sahc_pkg::SAHC_DECIDE: begin
                if (step_r == '0) begin
                    // Keep trial bit if input above DAC, MSB first
                    sar_nxt[bit_r] = cmp_s;
                    step_nxt = STEP_W'(STEP_CYCLES - 1);
                    if (bit_r == 4'h0) begin
                        state_nxt = sahc_pkg::SAHC_FINISH;
                    end else begin
                        sar_nxt[bit_r - 4'h1] = 1'b1;
                        bit_nxt = bit_r - 4'h1;
                    end
                end else begin
                    step_nxt = step_r - STEP_W'(1);
                end
            end
            sahc_pkg::SAHC_FINISH: begin
                // Format per variant: two's complement flips MSB of offset binary
                latch_nxt = sar_r;
                if (bip_r && !BYTE_VARIANT) begin
                    latch_nxt[`SAHC_MSB_IDX] = ~sar_r[`SAHC_MSB_IDX];
                end
                busy_n_nxt = 1'b1;
                state_nxt  = sahc_pkg::SAHC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r  <= sahc_pkg::SAHC_IDLE;
            cv_d_r   <= 1'b1;
            sar_r    <= '0;
            latch_r  <= '0;
            bit_r    <= 4'h0;
            step_r   <= '0;
            busy_n_r <= 1'b1;
            bip_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cv_d_r   <= cv_d_nxt;
            sar_r    <= sar_nxt;
            latch_r  <= latch_nxt;
            bit_r    <= bit_nxt;
            step_r   <= step_nxt;
            busy_n_r <= busy_n_nxt;
            bip_r    <= bip_nxt;
        end
    end

    // Power modes
    logic [CNT_W-1:0] wake_r, wake_nxt;
    logic [NAP_W-1:0] nap_r, nap_nxt;
    logic             ref_rdy_r, ref_rdy_nxt;
    logic             awake_r, awake_nxt;

    always_comb begin
        wake_nxt    = wake_r;
        ref_rdy_nxt = ref_rdy_r;
        nap_nxt     = nap_r;
        awake_nxt   = awake_r;
        if (!sl_s) begin
            wake_nxt    = '0;
            ref_rdy_nxt = 1'b0;
        end else if (!ref_rdy_r) begin
            if (wake_r == CNT_W'(WAKE_CYCLES - 1)) begin
                ref_rdy_nxt = 1'b1;
            end else begin
                wake_nxt = wake_r + CNT_W'(1);
            end
        end
        if (!np_s || !sl_s) begin
            nap_nxt   = '0;
            awake_nxt = 1'b0;
        end else if (!awake_r) begin
            if (nap_r == NAP_W'(NAP_CYCLES - 1)) begin
                awake_nxt = 1'b1;
            end else begin
                nap_nxt = nap_r + NAP_W'(1);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_r    <= '0;
            ref_rdy_r <= 1'b0;
            nap_r     <= '0;
            awake_r   <= 1'b0;
        end else begin
            wake_r    <= wake_nxt;
            ref_rdy_r <= ref_rdy_nxt;
            nap_r     <= nap_nxt;
            awake_r   <= awake_nxt;
        end
    end

    // Readout drivers
    logic [RES_BITS-1:0] dout_nxt;
    logic [RES_BITS-1:0] doe_nxt;
    logic                en;
    assign en = !rd_s && !cs2_r;

    // Fed from the next latch value so the result arrives with the busy rise
    always_comb begin
        dout_nxt = latch_nxt;
        doe_nxt  = en ? '1 : '0;
        if (BYTE_VARIANT) begin
            // Lines above the byte are never driven in the byte-wide variant
            doe_nxt[RES_BITS-1:`SAHC_BYTE_BITS] = '0;
            dout_nxt = '0;
            if (hb_s) begin
                dout_nxt[`SAHC_NIBBLE_BITS-1:0] =
                    latch_nxt[`SAHC_MSB_IDX:`SAHC_BYTE_BITS];
            end else begin
                dout_nxt[`SAHC_BYTE_BITS-1:0] = latch_nxt[`SAHC_BYTE_BITS-1:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o            <= '0;
            data_oe_o         <= '0;
            busy_n_o          <= 1'b1;
            reference_ready_o <= 1'b0;
            trial_word_o      <= '0;
            sample_hold_o     <= 1'b0;
            powered_down_o    <= 1'b1;
            core_awake_o      <= 1'b0;
        end else begin
            data_o            <= dout_nxt;
            data_oe_o         <= doe_nxt;
            busy_n_o          <= busy_n_nxt;
            reference_ready_o <= ref_rdy_nxt;
            trial_word_o      <= sar_nxt;
            sample_hold_o     <= (state_nxt != sahc_pkg::SAHC_IDLE);
            powered_down_o    <= !sl_s;
            core_awake_o      <= awake_nxt;
        end
    end

    // Checks: conversion sequencing
    sequence s_start_taken;
        state_r == sahc_pkg::SAHC_IDLE && start_evt;
    endsequence

    sequence s_bit_step;
        state_r == sahc_pkg::SAHC_DECIDE && step_r == '0 && bit_r != 4'h0;
    endsequence

    a_busy_low_conv: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r != sahc_pkg::SAHC_IDLE) |-> !busy_n_o)
        else $error("busy high during conversion");
    a_busy_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r == sahc_pkg::SAHC_IDLE) |-> busy_n_o)
        else $error("busy low while idle");
    a_busy_fall: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_start_taken |=> !busy_n_o && state_r == sahc_pkg::SAHC_SETTLE)
        else $error("accepted start did not lower busy");
    a_step_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_start_taken |=> step_r == STEP_W'(STEP_CYCLES - 1))
        else $error("step timer not loaded at start");
    a_start_gated: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r == sahc_pkg::SAHC_IDLE && cs2_r) |=> state_r == sahc_pkg::SAHC_IDLE)
        else $error("start without chip select");
    a_no_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r == sahc_pkg::SAHC_DECIDE) |=> state_r != sahc_pkg::SAHC_SETTLE)
        else $error("conversion restarted");
    a_bit_order: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_bit_step |=> bit_r == $past(bit_r) - 4'h1 && sar_r[bit_r])
        else $error("bit decisions out of order");
    a_bip_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r != sahc_pkg::SAHC_IDLE) |=> $stable(bip_r))
        else $error("polarity changed during conversion");
    a_sar_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_start_taken
        |=> sar_r == {1'b1, {(RES_BITS-1){1'b0}}})
        else $error("approximation register not cleared");
    a_latch_copy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r == sahc_pkg::SAHC_FINISH)
        |=> latch_r == (sar_r ^ {bip_r && !BYTE_VARIANT, {(RES_BITS-1){1'b0}}}))
        else $error("result latch not loaded");
    a_result_valid: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(busy_n_o) |-> latch_r[RES_BITS-2:0] == sar_r[RES_BITS-2:0]
            && (BYTE_VARIANT || data_o == latch_r))
        else $error("result not valid at busy rise");

    // Readout
    a_oe_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (rd_s || cs2_r) |=> data_oe_o == '0)
        else $error("outputs driven while deselected");
    a_oe_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        en |=> (BYTE_VARIANT ? data_oe_o[`SAHC_BYTE_BITS-1:0] == '1 : data_oe_o == '1))
        else $error("outputs not driven on read");
    a_full_word: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> (BYTE_VARIANT || data_o == latch_r))
        else $error("full word differs from latch");
    a_high_byte: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (BYTE_VARIANT && hb_s) |=> data_o == {{(RES_BITS-`SAHC_NIBBLE_BITS){1'b0}},
                                             latch_r[`SAHC_MSB_IDX:`SAHC_BYTE_BITS]})
        else $error("upper byte misplaced");
    a_low_byte: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (BYTE_VARIANT && !hb_s) |=> data_o == {{(RES_BITS-`SAHC_BYTE_BITS){1'b0}},
                                              latch_r[`SAHC_BYTE_BITS-1:0]})
        else $error("lower byte misplaced");

    // Power modes
    a_sleep_ref: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !sl_s |=> !reference_ready_o)
        else $error("reference ready during sleep");
    a_sleep_power: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !sl_s |=> powered_down_o)
        else $error("power-down flag low during sleep");
    a_ref_rise: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(reference_ready_o) |-> wake_r == CNT_W'(WAKE_CYCLES - 1))
        else $error("reference ready early");
    a_nap_core: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !np_s |=> !core_awake_o)
        else $error("core awake during nap");
    a_nap_wake: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(core_awake_o) |-> nap_r == NAP_W'(NAP_CYCLES - 1))
        else $error("core awake before nap wake-up");
endmodule : sahc_top
`default_nettype wire

// >>> testbench/sahc_host_model.sv
// Host model that latches the result on the busy rising edge
`default_nettype none
module sahc_host_model (
    input  wire logic        clock_i,
    input  wire logic        busy_n_i,
    input  wire logic [11:0] data_i,
    output var  logic [11:0] latched_o,
    output var  logic [15:0] conv_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q = 1'b1;
    initial conv_cnt_o = 16'h0000;
    always @(posedge clock_i) begin
        busy_q <= busy_n_i;
        if (busy_n_i && !busy_q) begin
            latched_o  <= data_i;
            conv_cnt_o <= conv_cnt_o + 16'h0001;
        end
    end
endmodule : sahc_host_model
`default_nettype wire

// >>> testbench/tb_sahc_top.sv
// Self-checking bench for the converter control block
`default_nettype none
module tb_sahc_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 1'b0, rst_n_i = 1'b0, cs_n = 1'b1, rd_n = 1'b1, cv_n = 1'b1;
    logic        ubs = 1'b0, slp_n = 1'b1, nap_n = 1'b1, bip = 1'b0;
    logic [11:0] tgt = 12'h000, ef, dat_a, oe_a, tr_a, dat_b, oe_b, tr_b, latched;
    logic [7:0]  eh, el;
    logic        busy_a, rdy_a, pd_a, awk_a, busy_b, sh_a;
    logic [15:0] cnt, cnt0;
    logic [11:0] hist [$];
    logic [40:0] rows [6] = '{{1'h0, 12'h000, 12'h000, 8'h00, 8'h00},
        {1'h0, 12'hFFF, 12'hFFF, 8'h0F, 8'hFF}, {1'h0, 12'hA5C, 12'hA5C, 8'h0A, 8'h5C},
        {1'h1, 12'h800, 12'h000, 8'h08, 8'h00}, {1'h1, 12'h7FF, 12'hFFF, 8'h07, 8'hFF},
        {1'h1, 12'h123, 12'h923, 8'h01, 8'h23}};
    int          error_cnt = 0, checks_done = 0, n, dur;
    wire logic   cmp_a = (tr_a <= tgt);
    wire logic   cmp_b = (tr_b <= tgt);
    always #5 clock_i = ~clock_i;
    sahc_top #(.WAKE_CYCLES(20)) sahc_top_inst (.clock_i, .rst_n_i, .chip_select_n_i(cs_n),
        .read_n_i(rd_n), .convert_start_n_i(cv_n), .upper_byte_select_i(ubs),
        .sleep_n_i(slp_n), .nap_n_i(nap_n), .bipolar_strap_i(bip), .comparator_i(cmp_a),
        .data_o(dat_a), .data_oe_o(oe_a), .busy_n_o(busy_a), .reference_ready_o(rdy_a),
        .trial_word_o(tr_a), .sample_hold_o(sh_a), .powered_down_o(pd_a), .core_awake_o(awk_a));
    sahc_top #(.WAKE_CYCLES(20), .BYTE_VARIANT(1'b1)) sahc_top_inst_b (.clock_i, .rst_n_i,
        .chip_select_n_i(cs_n), .read_n_i(rd_n), .convert_start_n_i(cv_n),
        .upper_byte_select_i(ubs), .sleep_n_i(slp_n), .nap_n_i(nap_n), .bipolar_strap_i(bip),
        .comparator_i(cmp_b), .data_o(dat_b), .data_oe_o(oe_b), .busy_n_o(busy_b),
        .reference_ready_o(), .trial_word_o(tr_b), .sample_hold_o(), .powered_down_o(),
        .core_awake_o());
    sahc_host_model sahc_host_model_inst (.clock_i, .busy_n_i(busy_a), .data_i(dat_a),
        .latched_o(latched), .conv_cnt_o(cnt));
    always @(posedge clock_i)
        if (!busy_a && (hist.size() == 0 || hist[$] !== tr_a) && tr_a !== 12'h000)
            hist.push_back(tr_a);
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic check(input logic [23:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask : cyc
    task automatic wait_for(input int sel, input logic v, input int lim);
        n = 0;
        while ((sel == 0 ? busy_a : sel == 1 ? awk_a : rdy_a) !== v && n < lim) begin
            cyc(1);
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            $display("Error at %0t: wait ran out", $time);
            close_out();
        end
    endtask : wait_for
    task automatic convert(input bit glitch);
        hist.delete();
        cs_n = 1'b0;
        cv_n = 1'b0;
        wait_for(0, 1'b0, 20);
        check({sh_a, busy_b}, 2'b10, "hold and second busy at start");
        cv_n = 1'b1;
        if (glitch) begin
            cyc(100);
            cv_n = 1'b0;
        end
        wait_for(0, 1'b1, 700);
        cv_n = 1'b1;
        dur = n + (glitch ? 100 : 0);
        check(24'(dur > 595 && dur < 602), 24'h1, "busy low length");
        check({sh_a, busy_b}, 2'b01, "hold and second busy at end");
        check({hist[0], hist[1]}, {12'h800, tgt[11], 11'h400}, "trial order");
        cyc(200);
    endtask : convert
    initial begin
        cyc(8);
        check({oe_a, 10'h0, busy_a, rdy_a}, 24'h000002, "during reset");
        rst_n_i = 1'b1;
        wait_for(2, 1'b1, 60);
        check(24'(n > 16 && n < 26), 24'h1, "ready after reset");
        wait_for(1, 1'b1, 100);
        for (int i = 0; i < 6; i++) begin
            {bip, tgt, ef, eh, el} = rows[i];
            rd_n = 1'b0;
            ubs = 1'b0;
            cyc(2);
            convert(1'b0);
            check(latched, ef, "latched at busy rise");
            check({oe_a, dat_a}, {12'hFFF, ef}, "full word");
            check({oe_b, dat_b[7:0]}, {12'h0FF, el}, "low byte");
            ubs = 1'b1;
            cyc(4);
            check({oe_b, dat_b[7:0]}, {12'h0FF, eh}, "high byte");
            $display("Row %0d done", i);
        end
        cs_n = 1'b1;
        cyc(5);
        check({oe_a, oe_b}, 24'h0, "cs high release");
        cv_n = 1'b0;
        cyc(10);
        check(busy_a, 1'b1, "start with cs high");
        cv_n = 1'b1;
        cs_n = 1'b0;
        rd_n = 1'b1;
        cyc(5);
        check({oe_a, oe_b}, 24'h0, "rd high release");
        $display("Select tests done");
        cnt0 = cnt;
        convert(1'b1);
        check(cnt, cnt0 + 16'h1, "one conversion");
        $display("Restart test done");
        slp_n = 1'b0;
        cyc(5);
        check({rdy_a, pd_a}, 2'b01, "sleep entry");
        cv_n = 1'b0;
        cyc(10);
        check(busy_a, 1'b1, "start in sleep");
        cv_n = 1'b1;
        slp_n = 1'b1;
        wait_for(2, 1'b1, 60);
        check(24'(n > 16 && n < 26), 24'h1, "wake delay");
        wait_for(1, 1'b1, 100);
        $display("Sleep test done");
        nap_n = 1'b0;
        cyc(5);
        check({awk_a, rdy_a}, 2'b01, "nap entry");
        nap_n = 1'b1;
        cyc(10);
        cv_n = 1'b0;
        cyc(10);
        check(busy_a, 1'b1, "start in nap wake");
        cv_n = 1'b1;
        wait_for(1, 1'b1, 100);
        check(24'(n > 35 && n < 50), 24'h1, "nap wake delay");
        tgt = 12'h3C3;
        convert(1'b0);
        $display("Nap test done");
        close_out();
    end
endmodule : tb_sahc_top
`default_nettype wire
